// ==== src/gpg_port_group.sv ====
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
`default_nettype none

// How it works
// - output-enabled GPIO pin drives its output level bit
// - output level bit stored while output disabled, pin unaffected
// - peripheral-owned pin ignores the output level bit
// - input level bit shows pin when input enabled, else zero
// - peripheral-owned pin reads zero in the input level bit
// - input and output both enabled: read back our own driven level
// - output disabled leaves the pin driver off (high impedance)
// - input/output enables ignored while a peripheral owns the pin
// - pull direction 1 up, 0 down, only with pull enable set
// - pull only while output disabled
// - pull bits ignored while a peripheral owns the pin
// - event flag set by cause, write 1 clears, 0 ignored
// - edge polarity 1 falling, 0 rising
// - event enable 1 permits a request, 0 suppresses it
// - debounce enable routes the pin through the filter for the input level bit and events only
// - owner bit 0 GPIO, 1 peripheral
// - two-bit function code per pin, pin 7 at top
// - function code effective only while owner bit is 1
// - filter clock control: debug run 8, divider 7-4, source 1-0
// - request only for a set flag with its enable set
// - summary bit follows enabled flags, clears with them
// - debounce rejects pulses shorter than two to three ticks
module gpg_port_group
  import gpg_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic RESET_N_I,
  input wire gpg_reg_req_t REG_REQ_I,
  output logic [GPG_DW-1:0] REG_RDATA_O,
  input wire logic PROT_OPEN_I,
  input wire logic DEBUG_I,
  input wire logic [GPG_SRC_N-1:0] SRC_TICK_I,
  input wire logic [GPG_PINS-1:0] PIN_IN_I,
  output logic [GPG_PINS-1:0] PIN_OUT_O,
  output logic [GPG_PINS-1:0] PIN_OE_O,
  output logic [GPG_PINS-1:0] PULL_EN_O,
  output logic [GPG_PINS-1:0] PULL_UP_O,
  input wire logic [GPG_PINS-1:0] PERIPH_OUT_I,
  input wire logic [GPG_PINS-1:0] PERIPH_OE_I,
  output logic [GPG_PINS-1:0] PERIPH_IN_O,
  output logic [GPG_PINS-1:0] PERIPH_SEL_O,
  output logic [GPG_PINS*GPG_ALT_W-1:0] FUNC_CODE_O,
  output logic EVENT_REQ_O
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_n;
  logic [GPG_PINS-1:0] output_level_bits_reg;
  logic [GPG_PINS-1:0] input_enable_bits_reg;
  logic [GPG_PINS-1:0] output_enable_bits_reg;
  logic [GPG_PINS-1:0] pull_direction_bits_reg;
  logic [GPG_PINS-1:0] pull_enable_bits_reg;
  logic [GPG_PINS-1:0] edge_event_flag_bits_reg;
  logic [GPG_PINS-1:0] edge_event_flag_bits_next;
  logic [GPG_PINS-1:0] edge_polarity_bits_reg;
  logic [GPG_PINS-1:0] edge_event_enable_bits_reg;
  logic [GPG_PINS-1:0] debounce_enable_bits_reg;
  logic [GPG_PINS-1:0] pin_owner_bits_reg;
  logic [GPG_PINS*GPG_ALT_W-1:0] alternate_function_code_reg;
  gpg_fclk_ctl_t fclk_reg;
  logic [GPG_PINS-1:0] sync_a_reg;
  logic [GPG_PINS-1:0] sync_b_reg;
  logic [GPG_PINS-1:0] sync_c_reg;
  logic [GPG_PINS-1:0] sync_lvl_reg;
  logic [GPG_PINS-1:0] filt_lvl;
  logic [GPG_PINS-1:0] pin_lvl;
  logic [GPG_PINS-1:0] prev_lvl_reg;
  logic [GPG_PINS-1:0] ev_set;
  logic [GPG_PINS-1:0] ev_clr;
  logic [GPG_PINS-1:0] input_level_bits;
  logic [GPG_DIVCNT_W-1:0] div_cnt_reg;
  logic ftick_reg;
  logic src_tick;
  logic summary;
  logic wr_en;
  logic [GPG_DW-1:0] wdata;
  logic [GPG_DW-1:0] rdata_next;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [GPG_AW-1:0] addr,
                               input logic [GPG_AW-1:0] off);
    hit = (addr == off);
  endfunction

  function automatic logic [GPG_DIVCNT_W-1:0] div_limit(
      input logic [GPG_DIV_W-1:0] div);
    div_limit = (GPG_DIVCNT_ONE << div) - GPG_DIVCNT_ONE;
  endfunction

  assign wr_en = REG_REQ_I.wr;
  assign wdata = REG_REQ_I.wdata;

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      output_level_bits_reg <= GPG_BYTE_RST;
    end else if (wr_en && hit(REG_REQ_I.addr, GPG_OFF_DATA)) begin
      // stored whatever the enables say
      output_level_bits_reg <= wdata[GPG_HI_LSB +: GPG_PINS];
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      input_enable_bits_reg <= GPG_BYTE_RST;
      output_enable_bits_reg <= GPG_BYTE_RST;
    end else if (wr_en && hit(REG_REQ_I.addr, GPG_OFF_DIR)) begin
      input_enable_bits_reg <= wdata[GPG_HI_LSB +: GPG_PINS];
      output_enable_bits_reg <= wdata[GPG_LO_LSB +: GPG_PINS];
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      pull_direction_bits_reg <= GPG_BYTE_RST;
      pull_enable_bits_reg <= GPG_BYTE_RST;
    end else if (wr_en && hit(REG_REQ_I.addr, GPG_OFF_PULL)) begin
      pull_direction_bits_reg <= wdata[GPG_HI_LSB +: GPG_PINS];
      pull_enable_bits_reg <= wdata[GPG_LO_LSB +: GPG_PINS];
    end
  end

  // software must clear a stale flag before enabling it
  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      edge_polarity_bits_reg <= GPG_BYTE_RST;
      edge_event_enable_bits_reg <= GPG_BYTE_RST;
    end else if (wr_en && hit(REG_REQ_I.addr, GPG_OFF_ECTL)) begin
      edge_polarity_bits_reg <= wdata[GPG_HI_LSB +: GPG_PINS];
      edge_event_enable_bits_reg <= wdata[GPG_LO_LSB +: GPG_PINS];
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      debounce_enable_bits_reg <= GPG_BYTE_RST;
    end else if (wr_en && hit(REG_REQ_I.addr, GPG_OFF_DEB)) begin
      debounce_enable_bits_reg <= wdata[GPG_LO_LSB +: GPG_PINS];
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      pin_owner_bits_reg <= GPG_BYTE_RST;
    end else if (wr_en && hit(REG_REQ_I.addr, GPG_OFF_OWN)) begin
      pin_owner_bits_reg <= wdata[GPG_LO_LSB +: GPG_PINS];
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      alternate_function_code_reg <= GPG_WORD_RST;
    end else if (wr_en && hit(REG_REQ_I.addr, GPG_OFF_ALT)) begin
      alternate_function_code_reg <= wdata;
    end
  end

  // protected fields: a write without the unlock level is dropped
  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      fclk_reg <= GPG_FCLK_RST;
    end else if (wr_en && PROT_OPEN_I &&
                 hit(REG_REQ_I.addr, GPG_OFF_FCLK)) begin
      fclk_reg.debug_run_enable <= wdata[GPG_DEBUG_RUN_ENABLE_BIT];
      fclk_reg.filter_clock_divider <= wdata[GPG_DIV_LSB +: GPG_DIV_W];
      fclk_reg.filter_clock_source <= wdata[GPG_SRC_LSB +: GPG_SRC_W];
    end
  end

  // ---------------------------------------------------------------
  // filter_clock tick
  // ---------------------------------------------------------------
  // halted in debug unless debug run is set; ticks come from the
  // clock generator as one-cycle strobes on the system clock
  assign src_tick = SRC_TICK_I[fclk_reg.filter_clock_source] &&
                    (!DEBUG_I || fclk_reg.debug_run_enable);

  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_reg <= GPG_DIVCNT_RST;
      ftick_reg <= 1'b0;
    end else if (!src_tick) begin
      ftick_reg <= 1'b0;
    end else if (div_cnt_reg >=
                 div_limit(fclk_reg.filter_clock_divider)) begin
      div_cnt_reg <= GPG_DIVCNT_RST;
      ftick_reg <= 1'b1;
    end else begin
      div_cnt_reg <= div_cnt_reg + GPG_DIVCNT_ONE;
      ftick_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // input path
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      sync_a_reg <= GPG_BYTE_RST;
      sync_b_reg <= GPG_BYTE_RST;
      sync_c_reg <= GPG_BYTE_RST;
    end else begin
      sync_a_reg <= PIN_IN_I;
      sync_b_reg <= sync_a_reg;
      sync_c_reg <= sync_b_reg;
    end
  end

  // a bit moves only where the last two stages agree
  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      sync_lvl_reg <= GPG_BYTE_RST;
    end else begin
      sync_lvl_reg <= (sync_b_reg & sync_c_reg) |
                      (sync_lvl_reg & (sync_b_reg ^ sync_c_reg));
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < GPG_PINS; gi++) begin : g_pin
      gpg_filter u_filter (
        .clk_i(CLK_SYS_I),
        .rst_n_i(rst_n),
        .tick_i(ftick_reg),
        .level_i(sync_lvl_reg[gi]),
        .level_o(filt_lvl[gi])
      );
    end
  endgenerate

  // toggling the debounce enable can fake an edge; keep events off
  // meanwhile
  assign pin_lvl = (debounce_enable_bits_reg & filt_lvl) |
                   (~debounce_enable_bits_reg & sync_lvl_reg);

  // ---------------------------------------------------------------
  // edge events
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      prev_lvl_reg <= GPG_BYTE_RST;
    end else begin
      prev_lvl_reg <= pin_lvl;
    end
  end

  // events only while the pin is a GPIO
  assign ev_set = ~pin_owner_bits_reg &
                  ((edge_polarity_bits_reg & prev_lvl_reg & ~pin_lvl) |
                   (~edge_polarity_bits_reg & ~prev_lvl_reg &
                    pin_lvl));
  assign ev_clr = (wr_en && hit(REG_REQ_I.addr, GPG_OFF_FLAG)) ?
                  wdata[GPG_LO_LSB +: GPG_PINS] : GPG_BYTE_RST;
  // a new cause wins over a simultaneous clear
  assign edge_event_flag_bits_next =
      (edge_event_flag_bits_reg & ~ev_clr) | ev_set;

  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      edge_event_flag_bits_reg <= GPG_BYTE_RST;
    end else begin
      edge_event_flag_bits_reg <= edge_event_flag_bits_next;
    end
  end

  assign summary = |(edge_event_flag_bits_reg &
                     edge_event_enable_bits_reg);

  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      EVENT_REQ_O <= 1'b0;
    end else begin
      EVENT_REQ_O <= summary;
    end
  end

  // ---------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      PIN_OUT_O <= GPG_BYTE_RST;
      PIN_OE_O <= GPG_BYTE_RST;
    end else begin
      PIN_OUT_O <= (pin_owner_bits_reg & PERIPH_OUT_I) |
                   (~pin_owner_bits_reg &
                    output_level_bits_reg);
      PIN_OE_O <= (pin_owner_bits_reg & PERIPH_OE_I) |
                  (~pin_owner_bits_reg &
                   output_enable_bits_reg);
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      PULL_EN_O <= GPG_BYTE_RST;
      PULL_UP_O <= GPG_BYTE_RST;
    end else begin
      PULL_EN_O <= ~pin_owner_bits_reg & pull_enable_bits_reg &
                   ~output_enable_bits_reg;
      PULL_UP_O <= ~pin_owner_bits_reg & pull_enable_bits_reg &
                   ~output_enable_bits_reg &
                   pull_direction_bits_reg;
    end
  end

  // ---------------------------------------------------------------
  // peripheral side
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      PERIPH_IN_O <= GPG_BYTE_RST;
      PERIPH_SEL_O <= GPG_BYTE_RST;
    end else begin
      PERIPH_IN_O <= pin_owner_bits_reg & sync_lvl_reg;
      PERIPH_SEL_O <= pin_owner_bits_reg;
    end
  end

  generate
    for (gi = 0; gi < GPG_PINS; gi++) begin : g_func
      always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
          FUNC_CODE_O[gi*GPG_ALT_W +: GPG_ALT_W] <= '0;
        end else if (pin_owner_bits_reg[gi]) begin
          FUNC_CODE_O[gi*GPG_ALT_W +: GPG_ALT_W] <=
              alternate_function_code_reg[gi*GPG_ALT_W +:
                                          GPG_ALT_W];
        end else begin
          FUNC_CODE_O[gi*GPG_ALT_W +: GPG_ALT_W] <= '0;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // read-back
  // ---------------------------------------------------------------
  // when driving, return our own level rather than the pin
  assign input_level_bits = input_enable_bits_reg &
                            ~pin_owner_bits_reg &
                            ((output_enable_bits_reg &
                              output_level_bits_reg) |
                             (~output_enable_bits_reg &
                              pin_lvl));

  always_comb begin
    rdata_next = GPG_WORD_RST;
    if (hit(REG_REQ_I.addr, GPG_OFF_DATA)) begin
      rdata_next[GPG_HI_LSB +: GPG_PINS] = output_level_bits_reg;
      rdata_next[GPG_LO_LSB +: GPG_PINS] = input_level_bits;
    end else if (hit(REG_REQ_I.addr, GPG_OFF_DIR)) begin
      rdata_next[GPG_HI_LSB +: GPG_PINS] = input_enable_bits_reg;
      rdata_next[GPG_LO_LSB +: GPG_PINS] = output_enable_bits_reg;
    end else if (hit(REG_REQ_I.addr, GPG_OFF_PULL)) begin
      rdata_next[GPG_HI_LSB +: GPG_PINS] = pull_direction_bits_reg;
      rdata_next[GPG_LO_LSB +: GPG_PINS] = pull_enable_bits_reg;
    end else if (hit(REG_REQ_I.addr, GPG_OFF_FLAG)) begin
      rdata_next[GPG_LO_LSB +: GPG_PINS] = edge_event_flag_bits_reg;
    end else if (hit(REG_REQ_I.addr, GPG_OFF_ECTL)) begin
      rdata_next[GPG_HI_LSB +: GPG_PINS] = edge_polarity_bits_reg;
      rdata_next[GPG_LO_LSB +: GPG_PINS] = edge_event_enable_bits_reg;
    end else if (hit(REG_REQ_I.addr, GPG_OFF_DEB)) begin
      rdata_next[GPG_LO_LSB +: GPG_PINS] = debounce_enable_bits_reg;
    end else if (hit(REG_REQ_I.addr, GPG_OFF_OWN)) begin
      rdata_next[GPG_LO_LSB +: GPG_PINS] = pin_owner_bits_reg;
    end else if (hit(REG_REQ_I.addr, GPG_OFF_ALT)) begin
      rdata_next = alternate_function_code_reg;
    end else if (hit(REG_REQ_I.addr, GPG_OFF_FCLK)) begin
      rdata_next[GPG_DEBUG_RUN_ENABLE_BIT] = fclk_reg.debug_run_enable;
      rdata_next[GPG_DIV_LSB +: GPG_DIV_W] =
          fclk_reg.filter_clock_divider;
      rdata_next[GPG_SRC_LSB +: GPG_SRC_W] =
          fclk_reg.filter_clock_source;
    end else if (hit(REG_REQ_I.addr, GPG_OFF_SUM)) begin
      rdata_next[GPG_SUM_BIT] = summary;
    end
  end

  // data stand for the one cycle after the read strobe only
  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      REG_RDATA_O <= GPG_WORD_RST;
    end else if (REG_REQ_I.rd) begin
      REG_RDATA_O <= rdata_next;
    end else begin
      REG_RDATA_O <= GPG_WORD_RST;
    end
  end

endmodule

`default_nettype wire

// ==== src/gpg_pkg.sv ====
package gpg_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int GPG_PINS = 8;
  localparam int GPG_AW = 8;
  localparam int GPG_DW = 16;
  localparam int GPG_ALT_W = 2;
  localparam int GPG_SRC_N = 4;
  localparam int GPG_DIV_W = 4;
  localparam int GPG_SRC_W = 2;
  localparam int GPG_DIVCNT_W = 15;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [GPG_AW-1:0] GPG_OFF_DATA = 8'h00;
  localparam logic [GPG_AW-1:0] GPG_OFF_DIR = 8'h02;
  localparam logic [GPG_AW-1:0] GPG_OFF_PULL = 8'h04;
  localparam logic [GPG_AW-1:0] GPG_OFF_FLAG = 8'h06;
  localparam logic [GPG_AW-1:0] GPG_OFF_ECTL = 8'h08;
  localparam logic [GPG_AW-1:0] GPG_OFF_DEB = 8'h0a;
  localparam logic [GPG_AW-1:0] GPG_OFF_OWN = 8'h0c;
  localparam logic [GPG_AW-1:0] GPG_OFF_ALT = 8'h0e;
  localparam logic [GPG_AW-1:0] GPG_OFF_FCLK = 8'h10;
  localparam logic [GPG_AW-1:0] GPG_OFF_SUM = 8'h12;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int GPG_HI_LSB = 8;
  localparam int GPG_LO_LSB = 0;
  localparam int GPG_DEBUG_RUN_ENABLE_BIT = 8;
  localparam int GPG_DIV_LSB = 4;
  localparam int GPG_SRC_LSB = 0;
  localparam int GPG_SUM_BIT = 0;
  localparam logic [GPG_PINS-1:0] GPG_BYTE_RST = 8'h00;
  localparam logic [GPG_DW-1:0] GPG_WORD_RST = 16'h0000;
  localparam logic [GPG_DIVCNT_W-1:0] GPG_DIVCNT_RST = 15'h0000;
  localparam logic [GPG_DIVCNT_W-1:0] GPG_DIVCNT_ONE = 15'h0001;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [GPG_AW-1:0] addr;
    logic [GPG_DW-1:0] wdata;
    logic wr;
    logic rd;
  } gpg_reg_req_t;

  typedef struct packed {
    logic debug_run_enable;
    logic [GPG_DIV_W-1:0] filter_clock_divider;
    logic [GPG_SRC_W-1:0] filter_clock_source;
  } gpg_fclk_ctl_t;

  localparam gpg_fclk_ctl_t GPG_FCLK_RST = '0;

endpackage

// ==== src/gpg_filter.sv ====
`timescale 1ns/1ns
`default_nettype none

// ---------------------------------------------------------------
// one-pin debounce: a level passes only after three agreeing
// samples on filter_clock ticks, so pulses shorter than two
// to three tick periods never reach the output
// ---------------------------------------------------------------
module gpg_filter (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic tick_i,
  input wire logic level_i,
  output logic level_o
);

  logic samp_a_reg;
  logic samp_b_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      samp_a_reg <= 1'b0;
      samp_b_reg <= 1'b0;
    end else if (tick_i) begin
      samp_a_reg <= level_i;
      samp_b_reg <= samp_a_reg;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_o <= 1'b0;
    end else if (tick_i && level_i == samp_a_reg &&
                 samp_a_reg == samp_b_reg) begin
      level_o <= level_i;
    end
  end

endmodule

`default_nettype wire

// ==== bench/gpg_port_group_sva.sv ====
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------
// port-level checks
// ---------------------------------------------
module gpg_port_group_sva
  import gpg_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic RESET_N_I,
  input wire gpg_reg_req_t REG_REQ_I,
  input wire logic [GPG_DW-1:0] REG_RDATA_O,
  input wire logic [GPG_PINS-1:0] PIN_OE_O,
  input wire logic [GPG_PINS-1:0] PULL_EN_O,
  input wire logic [GPG_PINS-1:0] PULL_UP_O,
  input wire logic [GPG_PINS-1:0] PERIPH_IN_O,
  input wire logic [GPG_PINS-1:0] PERIPH_SEL_O,
  input wire logic [GPG_PINS*GPG_ALT_W-1:0] FUNC_CODE_O,
  input wire logic EVENT_REQ_O
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESET_N_I);
  logic [15:0] sel2;
  logic [7:0] wlo;
  logic wr_own, wr_ectl, rd_fclk;
  assign wlo = REG_REQ_I.wdata[7:0];
  assign wr_own = REG_REQ_I.wr && REG_REQ_I.addr == GPG_OFF_OWN;
  assign wr_ectl = REG_REQ_I.wr && REG_REQ_I.addr == GPG_OFF_ECTL;
  assign rd_fclk = REG_REQ_I.rd && REG_REQ_I.addr == GPG_OFF_FCLK;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      sel2[2*i+:2] = {2{PERIPH_SEL_O[i]}};
    end
  end
  a_pull_vs_drive: assert property (
    (PULL_EN_O & PIN_OE_O) == 8'h00) else $error("pull while driving");
  a_pull_dir_gate: assert property (
    (PULL_UP_O & ~PULL_EN_O) == 8'h00) else $error("pull-up without pull");
  a_pull_periph_off: assert property (
    (PULL_EN_O & PERIPH_SEL_O) == 8'h00) else $error("pull on owned pin");
  a_func_gate: assert property (
    (FUNC_CODE_O & ~sel2) == 16'h0000) else $error("code on gpio pin");
  a_periph_in_gate: assert property (
    (PERIPH_IN_O & ~PERIPH_SEL_O) == 8'h00) else $error("input leaks");
  a_event_mask_off: assert property (
    wr_ectl && wlo == 8'h00 |-> ##2 !EVENT_REQ_O)
    else $error("request while disabled");
  a_owner_follow: assert property (
    wr_own |-> ##2 PERIPH_SEL_O == $past(wlo, 2))
    else $error("owner bits lag");
  a_fclk_rsvd_zero: assert property (
    rd_fclk |=> (REG_RDATA_O & 16'hfe0c) == 16'h0000)
    else $error("reserved bits set");
  c_event: cover property (EVENT_REQ_O);
  c_pull: cover property (|PULL_EN_O);
  c_func: cover property (|FUNC_CODE_O);
endmodule
bind gpg_port_group gpg_port_group_sva u_sva (.CLK_SYS_I(CLK_SYS_I),
  .RESET_N_I(RESET_N_I), .REG_REQ_I(REG_REQ_I), .REG_RDATA_O(REG_RDATA_O),
  .PIN_OE_O(PIN_OE_O), .PULL_EN_O(PULL_EN_O), .PULL_UP_O(PULL_UP_O),
  .PERIPH_IN_O(PERIPH_IN_O), .PERIPH_SEL_O(PERIPH_SEL_O),
  .FUNC_CODE_O(FUNC_CODE_O), .EVENT_REQ_O(EVENT_REQ_O));
`default_nettype wire

// ==== bench/gpg_pin_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------
// pad wires: device drive, outside driver, pull
// ---------------------------------------------
module gpg_pin_model (
  input wire logic clk_i,
  input wire logic [7:0] out_i,
  input wire logic [7:0] oe_i,
  input wire logic [7:0] pen_i,
  input wire logic [7:0] pup_i,
  input wire logic [7:0] ext_en_i,
  input wire logic [7:0] ext_lvl_i,
  output logic [7:0] pin_o
);
  // a floating pad toggles every cycle, which the input synchronizer reads as its last held level
  logic [7:0] float_q = 8'h55;
  always @(posedge clk_i) begin
    float_q <= ~float_q;
  end
  assign pin_o = (oe_i & out_i) | (~oe_i & ext_en_i & ext_lvl_i)
    | (~oe_i & ~ext_en_i & pen_i & pup_i)
    | (~oe_i & ~ext_en_i & ~pen_i & float_q);
endmodule
`default_nettype wire

// ==== bench/tb_gpio_port_group_control.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_gpio_port_group_control import gpg_pkg::*;;
  typedef struct packed {
    logic [15:0] dir, pull;
    logic [7:0] own, out, per;
    logic [55:0] exp;
  } gpg_row_t;
  // exp: oe, driven level, pull on, pull up, owner, codes
  gpg_row_t rows [4] = '{
    '{16'h00ff, 16'hffff, 8'h00, 8'ha5, 8'h00, 56'hffa50000000000},
    '{16'hff00, 16'hf0ff, 8'h00, 8'h5a, 8'h00, 56'h0000fff0000000},
    '{16'h000f, 16'h30f0, 8'h00, 8'h3c, 8'h00, 56'h0f0cf030000000},
    '{16'h00ff, 16'hffff, 8'hf0, 8'h0f, 8'h50, 56'h5f5f0000f0e400}};
  int lens [4] = '{4, 40, 4, 40};
  logic [7:0] debs [4] = '{8'h02, 8'h02, 8'h00, 8'h02};
  logic [7:0] fexp [4] = '{8'h00, 8'h02, 8'h02, 8'h00};
  logic clk, rst_n, prot, evt, dbg;
  logic [3:0] tick = 4'h0;
  logic [1:0] tcnt = 2'd0;
  logic [7:0] per, ext_en, ext_lvl, pin_in, pin_out, pin_oe, pen, pup;
  logic [7:0] p_in, sel;
  logic [15:0] rdata, fcode, d, d2;
  gpg_reg_req_t req;
  int fails, compares;
  gpg_port_group uut (.CLK_SYS_I(clk), .RESET_N_I(rst_n), .REG_REQ_I(req),
    .REG_RDATA_O(rdata), .PROT_OPEN_I(prot), .DEBUG_I(dbg),
    .SRC_TICK_I(tick), .PIN_IN_I(pin_in), .PIN_OUT_O(pin_out),
    .PIN_OE_O(pin_oe), .PULL_EN_O(pen), .PULL_UP_O(pup),
    .PERIPH_OUT_I(per), .PERIPH_OE_I(per), .PERIPH_IN_O(p_in),
    .PERIPH_SEL_O(sel), .FUNC_CODE_O(fcode), .EVENT_REQ_O(evt));
  gpg_pin_model u_pins (.clk_i(clk), .out_i(pin_out), .oe_i(pin_oe),
    .pen_i(pen), .pup_i(pup), .ext_en_i(ext_en), .ext_lvl_i(ext_lvl),
    .pin_o(pin_in));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // one filter source strobe every fourth cycle
  always @(posedge clk) begin
    tcnt <= tcnt + 2'd1;
    tick <= {3'b000, tcnt == 2'd0};
  end
  task automatic chk(input string n, input logic [63:0] e, s);
    compares++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk) req <= '{a, v, 1'b1, 1'b0};
    @(posedge clk) req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge clk) req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk) req.rd <= 1'b0;
    @(negedge clk) v = rdata;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic tally_and_finish;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    tally_and_finish;
  end
  initial begin
    req = '0; prot = 1'b0; per = 8'h00; ext_en = 8'h00; ext_lvl = 8'h00;
    rst_n = 1'b0; dbg = 1'b0; fails = 0; compares = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int a = 0; a <= 18; a += 2) begin
      rd(8'(a), d); chk("reset value", 16'h0000, d);
    end
    wr(8'h40, 16'hffff); rd(8'h40, d); chk("unmapped", 16'h0000, d);
    wr(GPG_OFF_ALT, 16'he4e4);
    foreach (rows[i]) begin
      @(posedge clk) per <= rows[i].per;
      wr(GPG_OFF_DIR, rows[i].dir); wr(GPG_OFF_PULL, rows[i].pull);
      wr(GPG_OFF_OWN, {8'h00, rows[i].own});
      wr(GPG_OFF_DATA, {rows[i].out, 8'h00});
      settle(3);
      chk("pins", rows[i].exp, {pin_oe, pin_out & pin_oe, pen, pup, sel,
        fcode});
      rd(GPG_OFF_DATA, d); rd(GPG_OFF_DIR, d2);
      chk("readback", {rows[i].dir, rows[i].out}, {d2, d[15:8]});
    end
    wr(GPG_OFF_OWN, 16'h0000); wr(GPG_OFF_PULL, 16'h0000);
    wr(GPG_OFF_DIR, 16'h0100);
    ext_en <= 8'h03; ext_lvl <= 8'h01; settle(8);
    rd(GPG_OFF_DATA, d); chk("input on", 8'h01, d[7:0]);
    wr(GPG_OFF_DIR, 16'h0000); settle(2);
    rd(GPG_OFF_DATA, d); chk("input off", 8'h00, d[7:0]);
    ext_en <= 8'h02; ext_lvl <= 8'h00;
    wr(GPG_OFF_DATA, 16'h0100); wr(GPG_OFF_DIR, 16'h0101); settle(8);
    rd(GPG_OFF_DATA, d); chk("own level", 8'h01, d[7:0]);
    wr(GPG_OFF_DIR, 16'h0100); ext_en <= 8'h03; ext_lvl <= 8'h01;
    wr(GPG_OFF_OWN, 16'h0001); settle(8);
    rd(GPG_OFF_DATA, d); chk("owned in", 9'h100, {p_in[0], d[7:0]});
    wr(GPG_OFF_OWN, 16'h0000); ext_lvl <= 8'h00; settle(8);
    wr(GPG_OFF_FLAG, 16'h00ff); wr(GPG_OFF_ECTL, 16'h0001);
    ext_lvl <= 8'h01; settle(10);
    rd(GPG_OFF_FLAG, d); chk("rise flag", 16'h0001, d);
    chk("request", 1'b1, evt);
    rd(GPG_OFF_SUM, d); chk("summary", 16'h0001, d);
    wr(GPG_OFF_FLAG, 16'h0000); rd(GPG_OFF_FLAG, d);
    chk("w0", 16'h0001, d);
    wr(GPG_OFF_FLAG, 16'h0001); settle(2); rd(GPG_OFF_FLAG, d);
    chk("cleared", 17'h0, {evt, d});
    wr(GPG_OFF_ECTL, 16'h0101); ext_lvl <= 8'h00; settle(10);
    rd(GPG_OFF_FLAG, d); chk("fall flag", 16'h0001, d);
    wr(GPG_OFF_ECTL, 16'h0100); settle(2); rd(GPG_OFF_SUM, d);
    chk("masked", 17'h0, {evt, d});
    wr(GPG_OFF_FLAG, 16'h0001); ext_lvl <= 8'h01; settle(10);
    rd(GPG_OFF_FLAG, d); chk("wrong edge", 16'h0000, d);
    ext_lvl <= 8'h00;
    // last pass: debug with debug run clear stops the filter clock
    for (int k = 0; k < 4; k++) begin
      wr(GPG_OFF_DEB, {8'h00, debs[k]}); dbg <= (k == 3); settle(40);
      wr(GPG_OFF_FLAG, 16'h00ff); ext_lvl[1] <= 1'b1;
      repeat (lens[k]) @(posedge clk);
      ext_lvl[1] <= 1'b0; settle(40);
      rd(GPG_OFF_FLAG, d);
      chk("debounce", fexp[k], d);
    end
    wr(GPG_OFF_FCLK, 16'hffff); rd(GPG_OFF_FCLK, d);
    chk("locked", 16'h0000, d);
    @(posedge clk) prot <= 1'b1;
    wr(GPG_OFF_FCLK, 16'hffff); rd(GPG_OFF_FCLK, d);
    chk("fields", 16'h01f3, d);
    tally_and_finish;
  end
endmodule
`default_nettype wire
